/* src/fcg_consts.svh */
// fcg_consts.svh - offsets, field positions, codes and reset values of the flash command guard
`ifndef FCG_CONSTS_SVH
`define FCG_CONSTS_SVH

// ============================================================
// register offsets
`define FCG_OFS_CLKDIV   16'h1820
`define FCG_OFS_OPTWORK  16'h1821
`define FCG_OFS_CONFIG   16'h1823
`define FCG_OFS_PROTWORK 16'h1824
`define FCG_OFS_STATUS   16'h1825
`define FCG_OFS_CMDCODE  16'h1826
`define FCG_OFS_KEY      16'hffb0
`define FCG_OFS_PROTECTION_NONVOLATILE   16'hffbd
`define FCG_OFS_OPTIONS_NONVOLATILE    16'hffbf

// ============================================================
// field positions
`define FCG_DIV_LOADED_BIT   7
`define FCG_PRESCALE8_BIT    6
`define FCG_KEY_ACCESS_BIT   5
`define FCG_KEY_ENABLE_BIT   7
`define FCG_PROT_OPEN_BIT    7
`define FCG_PROT_DIS_BIT     6
`define FCG_PROT_SIZE_LSB    3
`define FCG_ST_CBEF_BIT      7
`define FCG_ST_CCF_BIT       6
`define FCG_ST_PVIOL_BIT     5
`define FCG_ST_ACCERR_BIT    4
`define FCG_ST_BLANK_BIT     2
`define FCG_SEC_UNSECURED    2'h2

// ============================================================
// command codes
`define FCG_CMD_BLANK   8'h05
`define FCG_CMD_BYTE    8'h20
`define FCG_CMD_BURST   8'h25
`define FCG_CMD_PAGE    8'h40
`define FCG_CMD_MASS    8'h41

// ============================================================
// reset values and masks
`define FCG_RST_BYTE    8'h00
`define FCG_CONFIG_MASK 8'h20
`define FCG_PROT_MASK   8'hf8
`define FCG_OPT_MASK    8'hc3

`endif

/* src/fcg_pkg.sv */
// fcg_pkg.sv - types shared by the flash command guard files
package fcg_pkg;

  // ============================================================
  // command sequence states
  typedef enum logic [3:0] {
    FCG_IDLE = 4'b0001,
    FCG_ADDR = 4'b0010,
    FCG_CMD  = 4'b0100,
    FCG_BUSY = 4'b1000
  } fcg_state_t;

endpackage

/* src/fcg_key_mem.sv */
// fcg_key_mem.sv - small byte store holding the backdoor comparison key
`timescale 1ns/1ps
module fcg_key_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock
  input  wire logic             clk_in,
  // write port
  input  wire logic             we_in,
  input  wire logic [AW-1:0]    waddr_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  // read port
  input  wire logic [AW-1:0]    raddr_in,
  output logic      [WIDTH-1:0] rdata_out
);

  // ============================================================
  // storage, read data registered
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end

endmodule

/* src/fcg_guard.sv */
// fcg_guard.sv - flash command sequence checker, block protection and backdoor key
`timescale 1ns/1ps
`include "fcg_consts.svh"
module fcg_guard #(
  parameter logic [15:0] FLASH_LO   = 16'h8000,
  parameter int          BLOCK_UNIT = 512,
  parameter int          KEY_BYTES  = 8
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // processor and debug access
  input  wire logic [15:0] bus_addr_in,
  input  wire logic [7:0]  bus_wdata_in,
  input  wire logic        bus_wr_in,
  input  wire logic        bus_rd_in,
  input  wire logic        bus_bdm_in,
  output logic      [7:0]  bus_rdata_out,
  // system
  input  wire logic        stop_mode_in,
  input  wire logic [7:0]  nv_prot_in,
  input  wire logic [7:0]  nv_opt_in,
  input  wire logic        nv_key_we_in,
  input  wire logic [2:0]  nv_key_idx_in,
  input  wire logic [7:0]  nv_key_data_in,
  // flash array
  input  wire logic        array_done_in,
  input  wire logic        array_blank_in,
  output logic             array_go_out,
  output logic             array_abort_out,
  output logic [7:0]       array_cmd_out,
  output logic [15:0]      array_addr_out,
  output logic [7:0]       array_data_out,
  output logic             flash_clk_en_out,
  output logic             secured_out
);
  import fcg_pkg::*;

  // ============================================================
  // state
  fcg_state_t  state, next_state;
  logic [7:0]  clkdiv, next_clkdiv, config_reg, next_config, prot, next_prot, opt;
  logic        ccf, next_ccf, pviol, next_pviol, accerr, next_accerr, blank, next_blank;
  logic [7:0]  cmd, next_cmd, wdat, next_wdat, rdata, next_rdata;
  logic [15:0] addr, next_addr;
  logic        go, next_go, abort, next_abort;
  logic [8:0]  div_cnt, next_div_cnt;
  logic        fclk, next_fclk;
  logic [2:0]  key_idx, next_key_idx;
  logic        key_fail, next_key_fail, unlock, next_unlock;
  logic [7:0]  key_rd;

  // ============================================================
  // decode
  logic is_ctl, arr_wr, key_wr, cmd_wr, stat_wr, cmd_legal, cmd_dbg_bad, secured, cbef;
  logic prot_hit, any_prot, launch, err_seq;
  logic [16:0] prot_base;

  assign secured   = (opt[1:0] != `FCG_SEC_UNSECURED) && !unlock;
  assign cbef      = (state != FCG_BUSY);
  assign is_ctl    = (bus_addr_in >= `FCG_OFS_CLKDIV) && (bus_addr_in <= `FCG_OFS_CMDCODE);
  assign key_wr    = bus_wr_in && config_reg[`FCG_KEY_ACCESS_BIT]
                     && opt[`FCG_KEY_ENABLE_BIT]
                     && (bus_addr_in[15:3] == `FCG_OFS_KEY >> 3);
  assign arr_wr    = bus_wr_in && (bus_addr_in >= FLASH_LO) && !key_wr;
  assign cmd_wr    = bus_wr_in && (bus_addr_in == `FCG_OFS_CMDCODE);
  assign stat_wr   = bus_wr_in && (bus_addr_in == `FCG_OFS_STATUS);
  assign cmd_legal = (bus_wdata_in == `FCG_CMD_BLANK) || (bus_wdata_in == `FCG_CMD_BYTE)
                     || (bus_wdata_in == `FCG_CMD_BURST) || (bus_wdata_in == `FCG_CMD_PAGE)
                     || (bus_wdata_in == `FCG_CMD_MASS);
  assign cmd_dbg_bad = bus_bdm_in && secured && ((bus_wdata_in == `FCG_CMD_BYTE)
                     || (bus_wdata_in == `FCG_CMD_BURST)
                     || (bus_wdata_in == `FCG_CMD_PAGE));

  // protected block sits at the top of the map, its size set by the size field
  assign prot_base = 17'h10000 - 17'((BLOCK_UNIT) << prot[`FCG_PROT_SIZE_LSB +: 3]);
  assign any_prot  = !prot[`FCG_PROT_OPEN_BIT] || !prot[`FCG_PROT_DIS_BIT];
  // blank check only reads the array, so protection never stops it
  assign prot_hit  = (cmd == `FCG_CMD_BLANK) ? 1'b0
                   : (cmd == `FCG_CMD_MASS) ? any_prot
                   : (!prot[`FCG_PROT_OPEN_BIT]
                      || (!prot[`FCG_PROT_DIS_BIT] && ({1'b0, addr} >= prot_base)));
  assign launch    = (state == FCG_CMD) && stat_wr && bus_wdata_in[`FCG_ST_CBEF_BIT];

  // ============================================================
  // sequence checker
  always_comb begin
    next_state  = state;
    next_cmd    = cmd;
    next_addr   = addr;
    next_wdat   = wdat;
    next_go     = 1'b0;
    next_abort  = 1'b0;
    next_ccf    = ccf;
    next_blank  = blank;
    err_seq     = 1'b0;
    next_pviol  = pviol;
    next_accerr = accerr;
    // software clears flags by writing one; a set in the same cycle wins below
    if (state == FCG_IDLE && stat_wr) begin
      if (bus_wdata_in[`FCG_ST_PVIOL_BIT]) next_pviol = 1'b0;
      if (bus_wdata_in[`FCG_ST_ACCERR_BIT]) next_accerr = 1'b0;
    end
    case (state)
      FCG_IDLE: begin
        if (arr_wr && !clkdiv[`FCG_DIV_LOADED_BIT]) begin
          err_seq = 1'b1;
        end else if (arr_wr) begin
          next_state = FCG_ADDR;
          next_addr  = bus_addr_in;
          next_wdat  = bus_wdata_in;
        end
      end
      FCG_ADDR: begin
        if (arr_wr) begin
          err_seq = 1'b1;
        end else if (cmd_wr) begin
          if (!cmd_legal || cmd_dbg_bad) begin
            err_seq = 1'b1;
          end else begin
            next_state = FCG_CMD;
            next_cmd   = bus_wdata_in;
          end
        end else if (bus_wr_in && is_ctl) begin
          err_seq = 1'b1;
        end
      end
      FCG_CMD: begin
        if (launch) begin
          next_ccf = 1'b0;
          if (prot_hit) begin
            next_state = FCG_IDLE;
            next_pviol = 1'b1;
          end else begin
            next_state = FCG_BUSY;
            next_go    = 1'b1;
          end
        end else if (arr_wr || cmd_wr || (is_ctl && (bus_wr_in || bus_rd_in))) begin
          err_seq = 1'b1;
        end
      end
      FCG_BUSY: begin
        if (stop_mode_in) begin
          next_state  = FCG_IDLE;
          next_abort  = 1'b1;
          next_accerr = 1'b1;
        end else if (array_done_in) begin
          next_state = FCG_IDLE;
          next_ccf   = 1'b1;
          next_blank = array_blank_in;
        end
        if (arr_wr) next_accerr = 1'b1;
      end
      default: next_state = FCG_IDLE;
    endcase
    // an error drops whatever was buffered and leaves the array untouched
    if (err_seq) begin
      next_state  = FCG_IDLE;
      next_accerr = 1'b1;
    end
  end

  // ============================================================
  // control registers
  always_comb begin
    next_clkdiv = clkdiv;
    next_config = config_reg;
    next_prot   = prot;
    if (bus_wr_in && !err_seq && state == FCG_IDLE) begin
      if (bus_addr_in == `FCG_OFS_CLKDIV) begin
        next_clkdiv = {1'b1, bus_wdata_in[6:0]};
      end else if (bus_addr_in == `FCG_OFS_CONFIG) begin
        next_config = bus_wdata_in & `FCG_CONFIG_MASK;
      end else if (bus_addr_in == `FCG_OFS_PROTWORK && bus_bdm_in) begin
        next_prot = bus_wdata_in & `FCG_PROT_MASK;
      end
    end
  end

  always_comb begin
    next_rdata = `FCG_RST_BYTE;
    if (bus_rd_in) begin
      if (bus_addr_in == `FCG_OFS_CLKDIV) begin
        next_rdata = clkdiv;
      end else if (bus_addr_in == `FCG_OFS_OPTWORK) begin
        next_rdata = opt;
      end else if (bus_addr_in == `FCG_OFS_CONFIG) begin
        next_rdata = config_reg;
      end else if (bus_addr_in == `FCG_OFS_PROTWORK) begin
        next_rdata = prot;
      end else if (bus_addr_in == `FCG_OFS_STATUS) begin
        next_rdata = {cbef, ccf, pviol, accerr, 1'b0, blank, 2'b00};
      end else if (bus_addr_in == `FCG_OFS_CMDCODE) begin
        next_rdata = cmd;
      end
    end
  end

  // ============================================================
  // flash clock enable: divide by (div+1), times eight when prescaled
  always_comb begin
    next_div_cnt = div_cnt + 9'h001;
    next_fclk    = 1'b0;
    if (!clkdiv[`FCG_DIV_LOADED_BIT]) begin
      next_div_cnt = 9'h000;
    end else if (div_cnt >= (clkdiv[`FCG_PRESCALE8_BIT] ? {clkdiv[5:0], 3'h7}
                                                       : {3'h0, clkdiv[5:0]})) begin
      next_div_cnt = 9'h000;
      next_fclk    = 1'b1;
    end
  end

  // ============================================================
  // backdoor key compare; bytes must be written in order with a spare cycle
  // between them so the registered key byte has caught up
  always_comb begin
    next_key_idx  = key_idx;
    next_key_fail = key_fail;
    next_unlock   = unlock;
    if (key_wr) begin
      next_key_idx = key_idx + 3'h1;
      if (bus_addr_in[2:0] != key_idx || bus_wdata_in != key_rd) begin
        next_key_fail = 1'b1;
      end
      if (key_idx == 3'(KEY_BYTES - 1)) begin
        next_unlock   = !next_key_fail;
        next_key_fail = 1'b0;
      end
    end
  end

  fcg_key_mem #(
    .WIDTH (8),
    .DEPTH (KEY_BYTES)
  ) u_key (
    .clk_in    (clk_in),
    .we_in     (nv_key_we_in),
    .waddr_in  (nv_key_idx_in),
    .wdata_in  (nv_key_data_in),
    .raddr_in  (key_idx),
    .rdata_out (key_rd)
  );

  // ============================================================
  // registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state    <= FCG_IDLE;
      clkdiv   <= `FCG_RST_BYTE;
      config_reg <= `FCG_RST_BYTE;
      prot     <= nv_prot_in & `FCG_PROT_MASK;
      opt      <= nv_opt_in & `FCG_OPT_MASK;
      ccf      <= 1'b1;
      pviol    <= 1'b0;
      accerr   <= 1'b0;
      blank    <= 1'b0;
      cmd      <= `FCG_RST_BYTE;
      addr     <= 16'h0000;
      wdat     <= `FCG_RST_BYTE;
      go       <= 1'b0;
      abort    <= 1'b0;
      rdata    <= `FCG_RST_BYTE;
      div_cnt  <= 9'h000;
      fclk     <= 1'b0;
      key_idx  <= 3'h0;
      key_fail <= 1'b0;
      unlock   <= 1'b0;
    end else begin
      state    <= next_state;
      clkdiv   <= next_clkdiv;
      config_reg <= next_config;
      prot     <= next_prot;
      ccf      <= next_ccf;
      pviol    <= next_pviol;
      accerr   <= next_accerr;
      blank    <= next_blank;
      cmd      <= next_cmd;
      addr     <= next_addr;
      wdat     <= next_wdat;
      go       <= next_go;
      abort    <= next_abort;
      rdata    <= next_rdata;
      div_cnt  <= next_div_cnt;
      fclk     <= next_fclk;
      key_idx  <= next_key_idx;
      key_fail <= next_key_fail;
      unlock   <= next_unlock;
    end
  end

  logic sec_q;
  always_ff @(posedge clk_in) begin
    sec_q <= rst_in ? 1'b1 : secured;
  end

  assign bus_rdata_out    = rdata;
  assign array_go_out     = go;
  assign array_abort_out  = abort;
  assign array_cmd_out    = cmd;
  assign array_addr_out   = addr;
  assign array_data_out   = wdat;
  assign flash_clk_en_out = fclk;
  assign secured_out      = sec_q;

  // ============================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_div_first: assert property (
    (state == FCG_IDLE && arr_wr && !clkdiv[7]) |=> accerr && state == FCG_IDLE)
    else $error("array write before divider did not flag error");
  a_busy_write: assert property (
    (state == FCG_BUSY && arr_wr && !stop_mode_in && !array_done_in) |=> accerr && !cbef)
    else $error("array write while busy not flagged");
  a_second_addr: assert property (
    (state == FCG_ADDR && arr_wr) |=> accerr && state == FCG_IDLE)
    else $error("second array write not flagged");
  a_second_cmd: assert property (
    (state == FCG_CMD && cmd_wr) |=> accerr && state == FCG_IDLE && !go)
    else $error("second command write not flagged");
  a_ctl_after_addr: assert property (
    (state == FCG_ADDR && bus_wr_in && is_ctl && !cmd_wr) |=> accerr && state == FCG_IDLE)
    else $error("control write after address not flagged");
  a_bad_code: assert property (
    (state == FCG_ADDR && cmd_wr && !cmd_legal) |=> accerr && state != FCG_CMD)
    else $error("illegal command code accepted");
  a_cmd_read: assert property (
    (state == FCG_CMD && bus_rd_in && is_ctl) |=> accerr ##1 !go)
    else $error("control read after command not flagged");
  a_stop_abort: assert property (
    (state == FCG_BUSY && stop_mode_in) |=> abort && accerr && cbef ##1 !abort)
    else $error("stop mode did not abort command");
  a_secure_dbg: assert property (
    (state == FCG_ADDR && cmd_wr && cmd_dbg_bad) |=> accerr && state == FCG_IDLE)
    else $error("secured debug program command accepted");
  a_launch_go: assert property (
    (launch && !prot_hit) |=> go && !cbef && !ccf ##1 !go)
    else $error("launch did not start array");
  a_prot_block: assert property (
    (launch && prot_hit) |=> pviol && !go && state == FCG_IDLE)
    else $error("protected command reached array");
  a_prot_app: assert property (
    (bus_wr_in && bus_addr_in == `FCG_OFS_PROTWORK && !bus_bdm_in) |=> $stable(prot))
    else $error("application changed protection");

endmodule

/* testbench/fcg_array_model.sv */
// fcg_array_model.sv - behavioural flash array that answers start and abort requests
`timescale 1ns/1ps
`include "fcg_consts.svh"
module fcg_array_model (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // requests from the guard
  input  wire logic       go_in,
  input  wire logic       abort_in,
  input  wire logic [7:0] cmd_in,
  input  wire logic [7:0] latency_in,
  // answers to the guard
  output logic            done_out,
  output logic            blank_out
);
  logic [7:0] count;
  logic       busy;
  logic       is_blank;

  // ============================================================
  // the blank result is only valid with done; between answers it flips every cycle
  always_ff @(posedge clk_in) begin
    done_out  <= 1'b0;
    blank_out <= ~blank_out;
    if (rst_in) begin
      busy      <= 1'b0;
      count     <= 8'h00;
      blank_out <= 1'b0;
    end else if (abort_in) begin
      busy <= 1'b0;
    end else if (go_in) begin
      busy     <= 1'b1;
      count    <= latency_in;
      is_blank <= (cmd_in == `FCG_CMD_BLANK);
    end else if (busy) begin
      count <= count - 8'h01;
      if (count == 8'h00) begin
        busy      <= 1'b0;
        done_out  <= 1'b1;
        blank_out <= is_blank;
      end
    end
  end
endmodule

/* testbench/test_fcg_guard.sv */
// test_fcg_guard.sv - register-level tests of the flash command guard
`timescale 1ns/1ps
`include "fcg_consts.svh"
module test_fcg_guard;
  import fcg_pkg::*;
  logic        clk_in = 1'b0, rst_in = 1'b1, bus_wr_in = 1'b0, bus_rd_in = 1'b0;
  logic        bus_bdm_in = 1'b0, stop_mode_in = 1'b0, nv_key_we_in = 1'b0;
  logic [15:0] bus_addr_in = 16'h0000;
  logic [7:0]  bus_wdata_in = 8'h00, nv_prot_in = 8'hc0, nv_opt_in = 8'h02;
  logic [2:0]  nv_key_idx_in = 3'h0;
  logic [7:0]  nv_key_data_in = 8'h00, lat = 8'h03, bus_rdata_out, array_cmd_out, array_data_out;
  logic        array_done_in, array_blank_in, array_go_out, array_abort_out;
  logic        flash_clk_en_out, secured_out;
  logic [15:0] array_addr_out;
  int          fail_count = 0, samples_checked = 0, cycles = 0;
  int          go_count = 0, abort_count = 0, en_count = 0, g;
  logic [7:0]  go_cmd, d;
  logic [7:0]  codes [5] = '{`FCG_CMD_BLANK, `FCG_CMD_BYTE, `FCG_CMD_BURST,
                             `FCG_CMD_PAGE, `FCG_CMD_MASS};

  fcg_guard dut (.clk_in(clk_in), .rst_in(rst_in), .bus_addr_in(bus_addr_in),
    .bus_wdata_in(bus_wdata_in), .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
    .bus_bdm_in(bus_bdm_in), .bus_rdata_out(bus_rdata_out), .stop_mode_in(stop_mode_in),
    .nv_prot_in(nv_prot_in), .nv_opt_in(nv_opt_in), .nv_key_we_in(nv_key_we_in),
    .nv_key_idx_in(nv_key_idx_in), .nv_key_data_in(nv_key_data_in),
    .array_done_in(array_done_in), .array_blank_in(array_blank_in),
    .array_go_out(array_go_out), .array_abort_out(array_abort_out),
    .array_cmd_out(array_cmd_out), .array_addr_out(array_addr_out),
    .array_data_out(array_data_out), .flash_clk_en_out(flash_clk_en_out),
    .secured_out(secured_out));
  fcg_array_model array (.clk_in(clk_in), .rst_in(rst_in), .go_in(array_go_out),
    .abort_in(array_abort_out), .cmd_in(array_cmd_out), .latency_in(lat),
    .done_out(array_done_in), .blank_out(array_blank_in));

  initial begin
    forever #2 clk_in = ~clk_in;
  end

  // ============================================================
  // event counters and hang limit
  always @(posedge clk_in) begin
    cycles++;
    if (array_go_out === 1'b1) begin
      go_count++;
      go_cmd = array_cmd_out;
    end
    if (array_abort_out === 1'b1) abort_count++;
    if (flash_clk_en_out === 1'b1) en_count++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checked %0d values, %0d mismatches", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v, input logic bdm = 1'b0);
    @(negedge clk_in);
    bus_addr_in = a;
    bus_wdata_in = v;
    bus_bdm_in = bdm;
    bus_wr_in = 1'b1;
    @(negedge clk_in);
    bus_wr_in = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(negedge clk_in);
    bus_addr_in = a;
    bus_rd_in = 1'b1;
    @(negedge clk_in);
    bus_rd_in = 1'b0;
    d = bus_rdata_out;
  endtask

  task automatic launch(input logic [15:0] a, input logic [7:0] c, input logic bdm = 1'b0);
    wr(a, 8'h5c, bdm);
    wr(`FCG_OFS_CMDCODE, c, bdm);
    wr(`FCG_OFS_STATUS, 8'h80, bdm);
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (array_done_in !== 1'b1 && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    check(16'(n < 200), 16'h1);
    repeat (2) @(negedge clk_in);
  endtask

  task automatic do_reset(input logic [7:0] p, input logic [7:0] o);
    @(negedge clk_in);
    nv_prot_in = p;
    nv_opt_in = o;
    rst_in = 1'b1;
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
  endtask

  initial begin
    do_reset(8'hc0, 8'h02);
    rd(`FCG_OFS_STATUS); check(d, 8'hc0);
    rd(`FCG_OFS_PROTWORK); check(d, 8'hc0);
    rd(`FCG_OFS_OPTWORK); check(d, 8'h02);
    check(secured_out, 1'b0);
    wr(16'h8000, 8'h11);
    rd(`FCG_OFS_STATUS); check(d, 8'hd0);
    check(16'(go_count), 16'h0);
    wr(`FCG_OFS_STATUS, 8'h30);
    wr(`FCG_OFS_CLKDIV, 8'h01);
    rd(`FCG_OFS_CLKDIV); check(d, 8'h81);
    en_count = 0;
    repeat (20) @(negedge clk_in);
    check(16'(en_count), 16'd10);
    $display("test reset and divider done");
    for (int i = 0; i < 5; i++) begin
      g = go_count;
      launch(16'h8000 + 16'(i), codes[i]);
      wait_done();
      check(16'(go_count - g), 16'h1);
      check(go_cmd, codes[i]);
      check(array_addr_out, 16'h8000 + 16'(i));
      check(array_data_out, 8'h5c);
      rd(`FCG_OFS_STATUS);
      check(d, (i == 0) ? 8'hc4 : 8'hc0);
    end
    $display("test legal commands done");
    for (int k = 0; k < 7; k++) begin
      g = go_count;
      lat = 8'd40;
      wr(16'h8000, 8'h11);
      if (k == 0) wr(16'h8001, 8'h22);
      if (k == 1 || k == 3 || k == 4 || k == 5 || k == 6) begin
        wr(`FCG_OFS_CMDCODE, (k == 3) ? 8'h33 : `FCG_CMD_BYTE);
      end
      if (k == 1) wr(`FCG_OFS_CMDCODE, `FCG_CMD_BYTE);
      if (k == 2) wr(`FCG_OFS_CONFIG, 8'h00);
      if (k == 4) rd(`FCG_OFS_CLKDIV);
      if (k == 5) wr(`FCG_OFS_STATUS, 8'h00);
      if (k == 6) begin
        wr(`FCG_OFS_STATUS, 8'h80);
        wr(16'h8002, 8'h33);
        wait_done();
      end
      rd(`FCG_OFS_STATUS); check(d, 8'hd0);
      check(16'(go_count - g), (k == 6) ? 16'h1 : 16'h0);
      wr(`FCG_OFS_STATUS, 8'h30);
    end
    $display("test sequence errors done");
    g = abort_count;
    launch(16'h8000, `FCG_CMD_PAGE);
    stop_mode_in = 1'b1;
    @(negedge clk_in);
    stop_mode_in = 1'b0;
    repeat (3) @(negedge clk_in);
    check(16'(abort_count - g), 16'h1);
    rd(`FCG_OFS_STATUS); check(d & 8'h10, 8'h10);
    wr(`FCG_OFS_STATUS, 8'h30);
    lat = 8'h02;
    $display("test stop abort done");
    wr(`FCG_OFS_PROTWORK, 8'h88);
    rd(`FCG_OFS_PROTWORK); check(d, 8'hc0);
    wr(`FCG_OFS_PROTWORK, 8'h80, 1'b1);
    rd(`FCG_OFS_PROTWORK); check(d, 8'h80);
    for (int j = 0; j < 3; j++) begin
      g = go_count;
      launch((j == 1) ? 16'hfdff : 16'hfe00, (j == 2) ? `FCG_CMD_MASS : `FCG_CMD_BYTE);
      if (j == 1) wait_done();
      check(16'(go_count - g), (j == 1) ? 16'h1 : 16'h0);
      rd(`FCG_OFS_STATUS); check(d & 8'h20, (j == 1) ? 8'h00 : 8'h20);
      wr(`FCG_OFS_STATUS, 8'h30);
    end
    $display("test protection done");
    do_reset(8'h3f, 8'h7c);
    rd(`FCG_OFS_PROTWORK); check(d, 8'h38);
    rd(`FCG_OFS_OPTWORK); check(d, 8'h40);
    check(secured_out, 1'b1);
    wr(`FCG_OFS_CLKDIV, 8'h41);
    g = go_count;
    launch(16'h8000, `FCG_CMD_BYTE, 1'b1);
    rd(`FCG_OFS_STATUS); check(d, 8'hd0);
    wr(`FCG_OFS_STATUS, 8'h30);
    launch(16'h8000, `FCG_CMD_BLANK, 1'b1);
    wait_done();
    check(16'(go_count - g), 16'h1);
    $display("test secured debug done");
    do_reset(8'hc0, 8'h80);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_in);
      nv_key_we_in = 1'b1;
      nv_key_idx_in = 3'(i);
      nv_key_data_in = 8'h5a ^ 8'(i * 17);
      @(negedge clk_in);
      nv_key_we_in = 1'b0;
    end
    check(secured_out, 1'b1);
    wr(`FCG_OFS_CONFIG, 8'h20);
    rd(`FCG_OFS_CONFIG); check(d, 8'h20);
    for (int i = 0; i < 8; i++) wr(`FCG_OFS_KEY + 16'(i), 8'h5a ^ 8'(i * 17));
    repeat (4) @(negedge clk_in);
    check(secured_out, 1'b0);
    $display("test backdoor key done");
    summarize();
  end
endmodule
